//--- design/nrec_rx_config.sv
// rx config registers, crc control, correlator choice and disturbance checks
`timescale 1ns/1ps
module nrec_rx_config #(
   parameter int QCYC = nrec_pkg::QTR_CYC
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // transmit and mode status
   input  wire logic        tx_reqa_wupa_i,
   input  wire logic        antcl_i,
   input  wire logic [2:0]  rx_mode_i,
   input  wire logic [1:0]  stream_scf_i,
   input  wire logic [1:0]  stream_scp_i,
   // receive events
   input  wire logic        mask_receive_timer_expire_i,
   input  wire logic        subcarrier_det_i,
   input  wire logic        rx_nibble_done_i,
   input  wire logic        rx_nibble_err_i,
   input  wire logic        rx_frame_end_i,
   input  wire logic        rx_frame_err_i,
   input  wire logic [8:0]  rx_byte_count_i,
   // configuration outputs
   output logic             crc_check_en_o,
   output logic [1:0]       target_id_length_o,
   output logic             phase_clock_quarter_shift_o,
   output logic             correlator_en_o,
   output logic [1:0]       field_on_n_o,
   output logic             emd_enable_o,
   // receive results
   output logic             rx_start_o,
   output logic             frame_pass_o,
   output logic             frame_suppress_o,
   output logic             irq_o
);
   import nrec_pkg::*;

   logic [7:0]        aux_reg, emd_reg, sst_reg;
   logic [IRQ_W-1:0]  stat_reg, mask_reg, stat_set;
   nrec_state_t       st_reg, st_next;
   logic              auto_nocrc_reg;
   logic              discard_reg;
   logic              early;
   logic              wr_acc, rd_acc;
   logic [7:0]        idx;
   logic [7:0]        rd_byte;
   logic              isoa106, isob106, corr_ok, conflict;
   logic              short_frame, supp;
   logic              rxs_ev;

   assign idx = wb_adr_i[9:2];

   // bus phases: ack raised one cycle after the request, write taken on ack
   assign rd_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

   // acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) wb_ack_o <= 1'b0;
      else if (ce_i) wb_ack_o <= rd_acc;
   end

   // read multiplexer; unmapped indexes read zero
   always_comb begin
      case (idx)
         IDX_AUX:    rd_byte = aux_reg;
         IDX_EMD:    rd_byte = emd_reg;
         IDX_SST:    rd_byte = sst_reg;
         IDX_STATUS: rd_byte = {4'h0, stat_reg};
         IDX_MASK:   rd_byte = {4'h0, mask_reg};
         IDX_STATE:  rd_byte = {4'h0, discard_reg, st_reg};
         default:    rd_byte = 8'h00;
      endcase
   end

   // read data register
   always_ff @(posedge clk_i) begin
      if (rst_i) wb_dat_o <= 32'h0000_0000;
      else if (ce_i && rd_acc) wb_dat_o <= {24'h000000, rd_byte};
   end

   // configuration registers, reserved bits kept zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_reg <= AUX_RST;
         emd_reg <= EMD_RST;
         sst_reg <= SST_RST;
      end else if (ce_i && wr_acc) begin
         if (idx == IDX_AUX) aux_reg <= wb_dat_i[7:0] & AUX_WMASK;
         if (idx == IDX_EMD) emd_reg <= wb_dat_i[7:0] & EMD_WMASK;
         if (idx == IDX_SST) sst_reg <= wb_dat_i[7:0] & SST_WMASK;
      end
   end

   // mode decode
   assign isoa106 = (rx_mode_i == MODE_ISOA106);
   assign isob106 = (rx_mode_i == MODE_ISOB106);

   // correlator legality per mode
   always_comb begin
      case (rx_mode_i)
         MODE_ISOA106, MODE_ISOAHBR, MODE_T1T: corr_ok = 1'b1;
         MODE_ISOB106, MODE_ISOBHBR, MODE_F212: corr_ok = 1'b1;
         MODE_STREAM: corr_ok = (stream_scf_i == SCF_424) &&
                                (stream_scp_i == SCP_8);
         default: corr_ok = 1'b0;
      endcase
   end

   // combos marked not available: pulse for iso-a or type 1, correlator for other streams
   assign conflict = aux_reg[AUX_DCORR] ?
                     (rx_mode_i == MODE_ISOA106 || rx_mode_i == MODE_ISOAHBR ||
                      rx_mode_i == MODE_T1T) :
                     !corr_ok;

   // automatic no-crc from reqa/wupa until the answer frame ends
   always_ff @(posedge clk_i) begin
      if (rst_i) auto_nocrc_reg <= 1'b0;
      else if (ce_i) begin
         if (tx_reqa_wupa_i) auto_nocrc_reg <= 1'b1;
         else if (rx_frame_end_i) auto_nocrc_reg <= 1'b0;
      end
   end

   // registered configuration outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_check_en_o              <= 1'b1;
         target_id_length_o          <= ID_4B;
         phase_clock_quarter_shift_o <= 1'b0;
         correlator_en_o             <= 1'b1;
         field_on_n_o                <= 2'h0;
         emd_enable_o                <= 1'b0;
      end else if (ce_i) begin
         crc_check_en_o <= !aux_reg[AUX_NOCRC] && !auto_nocrc_reg &&
                           !tx_reqa_wupa_i && !antcl_i;
         target_id_length_o          <= aux_reg[AUX_IDLEN +: 2];
         phase_clock_quarter_shift_o <= aux_reg[AUX_PHASE];
         correlator_en_o <= !aux_reg[AUX_DCORR] && corr_ok;
         field_on_n_o    <= aux_reg[AUX_NVAL +: 2];
         emd_enable_o    <= emd_reg[EMD_EN];
      end
   end

   // subcarrier start timer
   nrec_sst_timer #(
      .QCYC (QCYC),
      .W    (SST_W)
   ) u_sst (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .start_i (mask_receive_timer_expire_i),
      .stop_i  (rx_frame_end_i),
      .subc_i  (subcarrier_det_i),
      .sst_i   (sst_reg[SST_W-1:0]),
      .early_o (early)
   );

   // receive tracking state
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         NREC_IDLE:   if (mask_receive_timer_expire_i) st_next = NREC_LISTEN;
         NREC_LISTEN: if (rx_nibble_done_i) st_next = NREC_FRAME;
         NREC_FRAME:  if (rx_frame_end_i) st_next = NREC_IDLE;
         default:     st_next = NREC_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) st_reg <= NREC_IDLE;
      else if (ce_i) st_reg <= st_next;
   end

   // frame marked for discard by an early subcarrier
   always_ff @(posedge clk_i) begin
      if (rst_i) discard_reg <= 1'b0;
      else if (ce_i) begin
         if (early && isob106 && emd_reg[EMD_EN]) discard_reg <= 1'b1;
         else if (rx_frame_end_i || mask_receive_timer_expire_i) discard_reg <= 1'b0;
      end
   end

   // rx start rule applies only to iso-a 106k
   assign rxs_ev = rx_nibble_done_i &&
                   (!isoa106 || !rx_nibble_err_i || emd_reg[EMD_SERR]);

   // erroneous short frame is disturbance
   assign short_frame = rx_byte_count_i < {5'h00, emd_reg[EMD_THLD +: 4]};
   assign supp = emd_reg[EMD_EN] &&
                 (discard_reg || (rx_frame_err_i && short_frame));

   // frame outcome pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_start_o       <= 1'b0;
         frame_pass_o     <= 1'b0;
         frame_suppress_o <= 1'b0;
      end else if (ce_i) begin
         rx_start_o       <= rxs_ev;
         frame_pass_o     <= rx_frame_end_i && !supp;
         frame_suppress_o <= rx_frame_end_i && supp;
      end
   end

   // interrupt events
   always_comb begin
      stat_set             = '0;
      stat_set[IRQ_RXS]    = rxs_ev;
      stat_set[IRQ_SOFT]   = early && isob106 && !emd_reg[EMD_EN];
      stat_set[IRQ_RST_EV] = (early && isob106 && emd_reg[EMD_EN]) ||
                             (rx_frame_end_i && supp);
      stat_set[IRQ_CONF]   = mask_receive_timer_expire_i && conflict;
   end

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) stat_reg <= IRQ_RST;
      else if (ce_i) begin
         if (wr_acc && idx == IDX_STATUS)
            stat_reg <= (stat_reg & ~wb_dat_i[IRQ_W-1:0]) | stat_set;
         else
            stat_reg <= stat_reg | stat_set;
      end
   end

   // interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) mask_reg <= IRQ_RST;
      else if (ce_i && wr_acc && idx == IDX_MASK) mask_reg <= wb_dat_i[IRQ_W-1:0];
   end

   // level interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) irq_o <= 1'b0;
      else if (ce_i) irq_o <= |(stat_reg & mask_reg);
   end

   // checks
   crc_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && aux_reg[AUX_NOCRC]) |=> !crc_check_en_o)
      else $error("crc check on while bypass set");

   crc_auto_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && tx_reqa_wupa_i) |=> !crc_check_en_o)
      else $error("crc check on after reqa or wupa");

   id_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> target_id_length_o == $past(aux_reg[5:4]))
      else $error("target id length not following register");

   corr_stream_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_mode_i == MODE_STREAM && stream_scf_i != SCF_424) |=> !correlator_en_o)
      else $error("correlator on in a pulse only stream mode");

   rx_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_nibble_done_i && isoa106 && rx_nibble_err_i && !emd_reg[EMD_SERR])
      |=> !rx_start_o)
      else $error("rx start raised on a bad first nibble");

   emd_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_frame_end_i && !emd_reg[EMD_EN]) |=> frame_pass_o && !frame_suppress_o)
      else $error("frame suppressed with suppression off");

   short_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_frame_end_i && emd_reg[EMD_EN] && rx_frame_err_i &&
       rx_byte_count_i < 9'(emd_reg[3:0])) |=> frame_suppress_o)
      else $error("short erroneous frame not suppressed");

   soft_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && early && isob106 && !emd_reg[EMD_EN]) |=> stat_reg[IRQ_SOFT])
      else $error("early subcarrier gave no soft error");

   restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && early && isob106 && emd_reg[EMD_EN]) |=>
      stat_reg[IRQ_RST_EV] && !$rose(stat_reg[IRQ_SOFT]) ##0 discard_reg)
      else $error("early subcarrier with suppression gave no restart");

   reset_zero_a: assert property (@(posedge clk_i)
      rst_i |=> aux_reg == 8'h00 && emd_reg == 8'h00 && sst_reg == 8'h00)
      else $error("config register not zero after reset");

   sst_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sst_reg[7:5] == 3'h0)
      else $error("reserved start timer bits set");

   phase_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> phase_clock_quarter_shift_o == $past(aux_reg[AUX_PHASE]))
      else $error("phase clock shift not following register");

   field_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> field_on_n_o == $past(aux_reg[1:0]))
      else $error("field-on count not following register");

   emd_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> emd_enable_o == $past(emd_reg[EMD_EN]))
      else $error("suppression enable not following register");

   pulse_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && aux_reg[AUX_DCORR]) |=> !correlator_en_o)
      else $error("correlator on while pulse reception selected");

   rx_start_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_nibble_done_i && !rx_nibble_err_i) |=> rx_start_o)
      else $error("rx start missing on a clean first nibble");

   early_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_nibble_done_i && emd_reg[EMD_SERR]) |=> rx_start_o)
      else $error("rx start missing with early error start set");

   soft_isob_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !isob106) |=> !$rose(stat_reg[IRQ_SOFT]))
      else $error("soft error raised outside iso-b 106");

   discard_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_frame_end_i && discard_reg && emd_reg[EMD_EN]) |=> frame_suppress_o)
      else $error("discarded frame passed on");
endmodule

//--- design/nrec_pkg.sv
// package: register map, fields, resets, events and timing of the rx config block
package nrec_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_EMD    = 8'h05;
   localparam logic [7:0] IDX_SST    = 8'h06;
   localparam logic [7:0] IDX_AUX    = 8'h0A;
   localparam logic [7:0] IDX_STATUS = 8'h10;
   localparam logic [7:0] IDX_MASK   = 8'h11;
   localparam logic [7:0] IDX_STATE  = 8'h12;
   // reset values
   localparam logic [7:0] AUX_RST  = 8'h00;
   localparam logic [7:0] EMD_RST  = 8'h00;
   localparam logic [7:0] SST_RST  = 8'h00;
   localparam logic [3:0] IRQ_RST  = 4'h0;
   // writable bits, reserved bits read zero
   localparam logic [7:0] AUX_WMASK = 8'hBF;
   localparam logic [7:0] EMD_WMASK = 8'hCF;
   localparam logic [7:0] SST_WMASK = 8'h1F;
   // auxiliary_receive_definition fields
   localparam int AUX_NOCRC = 7;
   localparam int AUX_IDLEN = 4;
   localparam int AUX_PHASE = 3;
   localparam int AUX_DCORR = 2;
   localparam int AUX_NVAL  = 0;
   // disturbance_suppression_config fields
   localparam int EMD_EN    = 7;
   localparam int EMD_SERR  = 6;
   localparam int EMD_THLD  = 0;
   // target id length codes
   localparam logic [1:0] ID_4B = 2'h0;
   localparam logic [1:0] ID_7B = 2'h1;
   // interrupt status bits
   localparam int IRQ_RXS  = 0;
   localparam int IRQ_SOFT = 1;
   localparam int IRQ_RST_EV = 2;
   localparam int IRQ_CONF = 3;
   localparam int IRQ_W    = 4;
   // receive mode codes
   localparam logic [2:0] MODE_ISOA106 = 3'h0;
   localparam logic [2:0] MODE_ISOAHBR = 3'h1;
   localparam logic [2:0] MODE_ISOB106 = 3'h2;
   localparam logic [2:0] MODE_ISOBHBR = 3'h3;
   localparam logic [2:0] MODE_F212    = 3'h4;
   localparam logic [2:0] MODE_T1T     = 3'h5;
   localparam logic [2:0] MODE_STREAM  = 3'h6;
   // stream codes that allow the correlator: fc/32 and 8 pulses
   localparam logic [1:0] SCF_424 = 2'h1;
   localparam logic [1:0] SCP_8   = 2'h3;
   // timing: one etu at 106 kb/s, start time step is a quarter etu
   localparam int ETU106_NS = 9440;
   localparam int CLK_MHZ   = 250;
   localparam int QTR_CYC   = (ETU106_NS * CLK_MHZ) / (4 * 1000);
   localparam int SST_W     = 5;
   // receive tracking states
   typedef enum logic [2:0] {
      NREC_IDLE   = 3'b001,
      NREC_LISTEN = 3'b010,
      NREC_FRAME  = 3'b100
   } nrec_state_t;
endpackage

//--- design/nrec_sst_timer.sv
// subcarrier start timer: flags a subcarrier seen too soon after mask expiry
`timescale 1ns/1ps
module nrec_sst_timer #(
   parameter int QCYC = 590,
   parameter int W    = 5
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   // control
   input  wire logic         start_i,
   input  wire logic         stop_i,
   input  wire logic         subc_i,
   input  wire logic [W-1:0] sst_i,
   // result
   output logic              early_o
);
   logic [15:0]  pre_reg;
   logic [W-1:0] qtr_reg;
   logic         run_reg;

   // quarter etu prescaler and saturating quarter count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_reg <= 16'h0000;
         qtr_reg <= '0;
         run_reg <= 1'b0;
      end else if (ce_i) begin
         if (start_i) begin
            pre_reg <= 16'h0000;
            qtr_reg <= '0;
            run_reg <= 1'b1;
         end else if (stop_i || subc_i) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            if (pre_reg == 16'(QCYC - 1)) begin
               pre_reg <= 16'h0000;
               if (qtr_reg != '1) qtr_reg <= qtr_reg + 1'b1;
            end else begin
               pre_reg <= pre_reg + 16'h0001;
            end
         end
      end
   end

   // elapsed time below the programmed start time is early
   always_ff @(posedge clk_i) begin
      if (rst_i) early_o <= 1'b0;
      else if (ce_i) early_o <= run_reg && subc_i && !start_i && (qtr_reg < sst_i);
   end
endmodule

//--- tb/nrec_tb.sv
// testbench for the rx config block: registers, crc control, receive events and interrupt
`timescale 1ns/1ps
module tb;
   import nrec_pkg::*;
   // clock, reset and wishbone
   logic        clk_i, rst_i, ce_i;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   // receive side stimulus and results
   logic        reqa, antcl, mexp, subc, nib, nib_err, fe, fe_err;
   logic [2:0]  mode;
   logic [1:0]  scf, scp, tid, fon;
   logic [8:0]  cnt;
   logic        crc, phase, corr, emd_on, rxs, pass, supp, irq;
   int          err_total, checked;

   // device under test with a short quarter etu
   nrec_rx_config #(.QCYC(4)) dut (
      .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_reqa_wupa_i(reqa), .antcl_i(antcl),
      .rx_mode_i(mode), .stream_scf_i(scf), .stream_scp_i(scp),
      .mask_receive_timer_expire_i(mexp),
      .subcarrier_det_i(subc), .rx_nibble_done_i(nib), .rx_nibble_err_i(nib_err),
      .rx_frame_end_i(fe), .rx_frame_err_i(fe_err), .rx_byte_count_i(cnt),
      .crc_check_en_o(crc), .target_id_length_o(tid), .phase_clock_quarter_shift_o(phase),
      .correlator_en_o(corr), .field_on_n_o(fon), .emd_enable_o(emd_on), .rx_start_o(rxs),
      .frame_pass_o(pass), .frame_suppress_o(supp), .irq_o(irq));

   // 250 MHz clock
   initial begin
      clk_i = 1'h0;
      forever #2 clk_i = ~clk_i;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic summarize();
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // classic single wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] sel, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_sel_i <= sel;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 64);
      chk(wb_ack_o, 1'h1, "bus ack");
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i  <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb(1'h1, idx, d, 4'hF, q);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] q;
      wb(1'h0, idx, 8'h00, 4'hF, q);
      chk(q, exp, what);
   endtask

   // one-cycle event: 0 mask expiry, 1 subcarrier, 2 nibble, 3 frame end, else reqa
   task automatic ev(input int k, input logic err, input logic [8:0] n);
      @(posedge clk_i);
      case (k)
         0: mexp <= 1'h1;
         1: subc <= 1'h1;
         2: begin
            nib     <= 1'h1;
            nib_err <= err;
         end
         3: begin
            fe     <= 1'h1;
            fe_err <= err;
            cnt    <= n;
         end
         default: reqa <= 1'h1;
      endcase
      @(posedge clk_i);
      {mexp, subc, nib, fe, reqa} <= 5'h00;
      #1;
   endtask

   // reset values, field outputs, reserved bits, byte enable and unmapped index
   task automatic t_regs();
      logic [7:0]  v [7] = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h03, 8'h80, 8'hFF};
      logic [31:0] q;
      rdchk(IDX_AUX, 32'h0, "aux reset");
      rdchk(IDX_EMD, 32'h0, "emd reset");
      rdchk(IDX_SST, 32'h0, "sst reset");
      chk({crc, corr, tid, phase, fon, emd_on}, 8'hC0, "outputs after reset");
      foreach (v[i]) begin
         wr(IDX_AUX, v[i]);
         rdchk(IDX_AUX, {24'h0, v[i] & 8'hBF}, "aux readback");
         chk({crc, tid, phase, corr, fon},
             {~v[i][7], v[i][5:4], v[i][3], ~v[i][2], v[i][1:0]},
             "aux fields");
      end
      wb(1'h1, IDX_AUX, 8'h00, 4'h0, q);
      rdchk(IDX_AUX, 32'hBF, "write without byte enable");
      rdchk(8'h0F, 32'h0, "unmapped read");
      // bypass bits cleared before suppression is turned on
      wr(IDX_AUX, 8'h00);
      wr(IDX_EMD, 8'hFF);
      rdchk(IDX_EMD, 32'hCF, "emd readback");
      chk(emd_on, 1'h1, "suppression enable");
      wr(IDX_SST, 8'hFF);
      rdchk(IDX_SST, 32'h1F, "sst reserved bits");
      wr(IDX_EMD, 8'h00);
   endtask

   // crc check dropped by anticollision and by reqa until frame end
   task automatic t_crc();
      // clock enable low freezes the registered outputs
      tick(1);
      ce_i  <= 1'h0;
      antcl <= 1'h1;
      tick(3);
      #1 chk(crc, 1'h1, "crc frozen while disabled");
      tick(1);
      ce_i <= 1'h1;
      tick(1);
      antcl <= 1'h1;
      tick(2);
      #1 chk(crc, 1'h0, "crc during anticollision");
      tick(1);
      antcl <= 1'h0;
      ev(4, 1'h0, 9'h000);
      tick(3);
      #1 chk(crc, 1'h0, "crc after reqa");
      ev(3, 1'h0, 9'h005);
      tick(2);
      #1 chk(crc, 1'h1, "crc after frame end");
   endtask

   // correlator allowed for every mode with the fc/32, 8 pulse stream codes
   task automatic t_corr();
      for (int m = 0; m < 7; m++) begin
         tick(1);
         mode <= m[2:0];
         scf  <= 2'h1;
         scp  <= 2'h3;
         tick(2);
         #1 chk(corr, 1'h1, "correlator by mode");
      end
      tick(1);
      scf <= 2'h0;
      tick(2);
      #1 chk(corr, 1'h0, "other stream code");
      tick(1);
      mode <= MODE_ISOB106;
      wr(IDX_AUX, 8'h04);
      tick(2);
      chk(corr, 1'h0, "pulse reception");
      wr(IDX_AUX, 8'h00);
      mode <= MODE_ISOA106;
   endtask

   // receive start per first nibble error, early start bit and mode
   task automatic t_nib();
      logic [5:0] t [4] = '{6'h01, 6'h02, 6'h07, 6'h13};
      foreach (t[i]) begin
         wr(IDX_EMD, {1'h0, t[i][2], 6'h00});
         mode <= t[i][5:3];
         ev(0, 1'h0, 9'h000);
         ev(2, t[i][1], 9'h000);
         chk(rxs, t[i][0], "rx start");
      end
   endtask

   // length based suppression with threshold four: {enable, error, suppress, count}
   task automatic t_len();
      logic [11:0] t [4] = '{{3'h7, 9'h003}, {3'h6, 9'h004}, {3'h4, 9'h003}, {3'h2, 9'h003}};
      foreach (t[i]) begin
         wr(IDX_EMD, {t[i][11], 3'h0, 4'h4});
         ev(0, 1'h0, 9'h000);
         ev(3, t[i][10], t[i][8:0]);
         chk({pass, supp}, {~t[i][9], t[i][9]}, "frame verdict");
      end
   endtask

   // early subcarrier, interrupt mask and clear, restart under suppression
   task automatic t_sst();
      logic [31:0] q;
      wr(IDX_EMD, 8'h00);
      wr(IDX_SST, 8'h02);
      wr(IDX_STATUS, 8'h0F);
      wr(IDX_MASK, 8'h02);
      mode <= MODE_ISOB106;
      ev(0, 1'h0, 9'h000);
      ev(1, 1'h0, 9'h000);
      rdchk(IDX_STATUS, 32'h2, "soft error");
      chk(irq, 1'h1, "irq raised");
      wr(IDX_MASK, 8'h00);
      tick(3);
      chk(irq, 1'h0, "irq masked");
      wr(IDX_MASK, 8'h02);
      tick(3);
      chk(irq, 1'h1, "irq unmasked");
      wr(IDX_STATUS, 8'h02);
      tick(3);
      chk(irq, 1'h0, "irq cleared");
      ev(0, 1'h0, 9'h000);
      tick(20);
      ev(1, 1'h0, 9'h000);
      rdchk(IDX_STATUS, 32'h0, "late subcarrier");
      wr(IDX_EMD, 8'h84);
      ev(0, 1'h0, 9'h000);
      ev(1, 1'h0, 9'h000);
      ev(3, 1'h0, 9'h00A);
      chk({pass, supp}, 2'h1, "early frame dropped");
      wb(1'h0, IDX_STATUS, 8'h00, 4'hF, q);
      chk(q[2], 1'h1, "restart event");
   endtask

   // main sequence
   initial begin
      err_total = 0;
      checked   = 0;
      rst_i     = 1'h1;
      ce_i      = 1'h1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i  = 10'h000;
      wb_sel_i  = 4'h0;
      wb_dat_i  = 32'h0;
      {reqa, antcl, mexp, subc, nib, nib_err, fe, fe_err} = 8'h00;
      mode = MODE_ISOA106;
      {scf, scp} = 4'h0;
      cnt = 9'h000;
      tick(10);
      rst_i <= 1'h0;
      t_regs();
      t_crc();
      t_corr();
      t_nib();
      t_len();
      t_sst();
      summarize();
   end

   // watchdog against a hung handshake
   initial begin
      #100000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
endmodule
